// File: design/kpi_interp.sv
// keypad programming-mode interpreter: entry, field access, pages and exits
`timescale 1ns/1ps
module kpi_interp #(
    parameter logic [31:0] POWERUP_CYC = kpi_pkg::POWERUP_CYCLES
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // keypad side
    input  wire kpi_pkg::kpi_key_type kp_key_in,
    input  wire logic              kp_chord_in,
    input  wire logic [4:0]        kp_addr_in,
    input  wire logic              kp_two_line_in,
    // downloading link side
    input  wire kpi_pkg::kpi_key_type dl_key_in,
    input  wire logic              dl_enter_in,
    input  wire logic              dl_local_dis_in,
    // system configuration
    input  wire logic [3:0]        part_count_in,
    // status and display
    output kpi_pkg::kpi_disp_type  disp_out,
    output logic                   prog_mode_out,
    output logic                   menu_mode_out,
    output logic                   locked_out,
    output logic                   part_mode_out,
    output logic [3:0]             part_sel_out,
    output logic                   beep3_out
);
    import kpi_pkg::*;

    // whole interpreter state in one record:
    // st/page/fld track where the operator is,
    // rd remembers whether the prefix was a pound (read) or a star (write),
    // d1 holds the tens digit of a field number until the units digit arrives,
    // acc/cnt collect data digits, msd first, until the field length is met,
    // hist is a shift register of the last eight digits keyed while idle,
    // pu_cnt saturates once the chord window has closed,
    // mem is the retained field store, one word per page and field
    typedef struct packed {
        kpi_state_type st;
        logic [1:0]    page;
        logic [6:0]    fld;
        logic          rd;
        logic [3:0]    d1;
        logic [15:0]   acc;
        logic [2:0]    cnt;
        logic          part_mode;
        logic [3:0]    part;
        logic          locked;
        logic [31:0]   pu_cnt;
        logic [31:0]   hist;
        logic [KP_N-1:0] kp_en;
        kpi_disp_type  disp;
        logic          beep;
        logic [NPAGES-1:0][NFIELDS-1:0][15:0] mem;
    } kpi_st_type;

    kpi_st_type s_r;
    kpi_st_type s_nxt;

    // link keys win over keypad keys in the same cycle, so a keypad key
    // that coincides with a link key is lost; keypad keys in other cycles still apply;
    // keypads outside the enabled address set are dropped silently,
    // which keeps a freshly defaulted panel programmable only from the
    // two keypad addresses that defaults enable
    // key source: link keys always, keypad keys only from an enabled address
    logic        kp_ok;
    kpi_key_type key;
    logic        is_dig;
    logic [6:0]  num;
    logic [6:0]  nf;
    logic        fld_ok;
    logic [2:0]  len;
    logic        win_open;

    assign kp_ok  = s_r.kp_en[kp_addr_in];
    assign key    = dl_key_in.valid ? dl_key_in : ((kp_key_in.valid && kp_ok) ?
                    kp_key_in : '0);
    assign is_dig = key.valid && (key.code <= KEY_DIG_MAX);
    // widen the tens digit before the product so that 90 and above survive
    assign num    = 7'(s_r.d1) * 7'd10 + {3'h0, key.code};
    assign win_open = (s_r.pu_cnt < POWERUP_CYC);
    assign len    = (s_r.page == 2'h0 && s_r.fld == FLD_CODE) ? LEN_CODE : LEN_FIELD;

    // each page has its own legal field range; the second page starts at
    // field 01, the others at field 00, so a number that is legal on one
    // page may give an address error on another
    // field address check per page
    function automatic logic addr_ok(input logic [1:0] pg, input logic [6:0] f);
        logic r;
        r = 1'b0;
        case (pg)
            2'h0:    r = (f <= P0_MAX);
            2'h1:    r = (f >= P1_MIN) && (f <= P1_MAX);
            2'h2:    r = (f <= P2_MAX);
            default: r = 1'b0;
        endcase
        return r;
    endfunction : addr_ok

    // partition-specific fields live only on the first page; they are
    // stored once here rather than per partition, a known limitation
    function automatic logic is_part(input logic [1:0] pg, input logic [6:0] f);
        return (pg == 2'h0) && (f >= PART_LO) && (f <= PART_HI);
    endfunction : is_part

    // next-state logic
    // one key is consumed per cycle; every branch starts from the held
    // state so that a key that does not apply leaves everything as it was;
    // the beep pulse is cleared here each cycle so it lasts one cycle only;
    // the power-up counter runs in every state and stops at the window end,
    // so the chord stays refused until the next reset
    always_comb begin
        s_nxt = s_r;
        s_nxt.beep = 1'b0;
        nf = '0;
        fld_ok = 1'b0;
        if (win_open) begin
            s_nxt.pu_cnt = s_r.pu_cnt + 32'h0000_0001;
        end
        case (s_r.st)
            ST_IDLE: begin
                // idle: watch for the chord, a link entry, or the installer
                // code followed by the entry tail; the history only holds
                // digits so stray star or pound keys do not break a sequence;
                // the link entry ignores lockout and local disable on purpose
                if (is_dig) begin
                    s_nxt.hist = {s_r.hist[27:0], key.code};
                end
                if (dl_enter_in
                    || (kp_chord_in && win_open && !dl_local_dis_in)
                    || (is_dig && !s_r.locked && !dl_local_dis_in
                        && ({s_r.hist[27:0], key.code} ==
                            {s_r.mem[0][FLD_CODE], ENTER_TAIL}))) begin
                    s_nxt.st = ST_CMD;
                    s_nxt.page = 2'h0;
                    s_nxt.fld = FLD_CODE;
                    s_nxt.part_mode = 1'b0;
                    s_nxt.hist = '0;
                    s_nxt.disp = '{DSP_PROMPT, 2'h0, FLD_CODE, 16'h0000};
                end
            end
            ST_CMD, ST_MENU, ST_DATA: begin
                // a prefix key always starts a new field address, which is
                // also how a short entry or an entry error is abandoned;
                // data digits only count while a field is open for writing,
                // and the display shows them as they arrive
                if (key.valid && (key.code == KEY_STAR || key.code == KEY_POUND)) begin
                    s_nxt.st = ST_FLD1;
                    s_nxt.rd = (key.code == KEY_POUND);
                end else if (s_r.st == ST_DATA && is_dig) begin
                    s_nxt.acc = {s_r.acc[11:0], key.code};
                    s_nxt.cnt = s_r.cnt + 3'h1;
                    s_nxt.disp.data = {s_r.acc[11:0], key.code};
                    if (s_r.cnt + 3'h1 == len) begin
                        if (len == LEN_FIELD && {s_r.acc[11:0], key.code} > FIELD_MAX) begin
                            s_nxt.st = ST_CMD;
                            s_nxt.disp.mode = DSP_BLANK;
                        end else begin
                            s_nxt.mem[s_r.page][s_r.fld] = {s_r.acc[11:0], key.code};
                            s_nxt.beep = 1'b1;
                            s_nxt.st = ST_CMD;
                            nf = s_r.fld + 7'h01;
                            if (s_r.part_mode && !is_part(s_r.page, nf)) begin
                                s_nxt.part_mode = 1'b0;
                                nf = FLD_CODE;
                            end else if (!s_r.part_mode && part_count_in != 4'h1
                                         && is_part(s_r.page, nf)) begin
                                nf = PART_HI + 7'h01;
                            end
                            if (!addr_ok(s_r.page, nf)) begin
                                nf = s_r.fld;
                            end
                            s_nxt.fld = nf;
                            s_nxt.st = ST_DATA;
                            s_nxt.acc = '0;
                            s_nxt.cnt = '0;
                            s_nxt.disp = '{DSP_ENTRY, s_r.page, nf, s_r.mem[s_r.page][nf]};
                        end
                    end
                end
            end
            ST_FLD1: begin
                if (is_dig) begin
                    s_nxt.d1 = key.code;
                    s_nxt.st = ST_FLD2;
                end else if (key.valid) begin
                    s_nxt.st = ST_CMD;
                    s_nxt.disp.mode = DSP_FC;
                end
            end
            ST_FLD2: begin
                // second digit of the address: numbers above the first
                // page's range are commands when written with a star;
                // with a pound they go through the address check instead,
                // so a pound command gives an address error
                if (key.valid && !is_dig) begin
                    s_nxt.st = ST_CMD;
                    s_nxt.disp.mode = DSP_FC;
                end else if (is_dig && !s_r.rd && num > P0_MAX) begin
                    s_nxt.st = ST_CMD;
                    s_nxt.disp.mode = DSP_FC;
                    case (num)
                        CMD_PART: begin
                            s_nxt.st = ST_PART;
                            s_nxt.disp.mode = DSP_PARTQ;
                        end
                        CMD_REV: begin
                            s_nxt.disp = '{DSP_REV, s_r.page, s_r.fld, SW_REV};
                        end
                        CMD_MENU: begin
                            if (kp_two_line_in || dl_key_in.valid) begin
                                s_nxt.st = ST_MENU;
                                s_nxt.disp.mode = DSP_MENU;
                            end
                        end
                        CMD_NEXT: begin
                            if (s_r.page != PAGE_LAST) begin
                                s_nxt.page = s_r.page + 2'h1;
                                s_nxt.fld = (s_r.page == 2'h0) ? P1_MIN : FLD_CODE;
                                s_nxt.part_mode = 1'b0;
                                s_nxt.disp = '{DSP_PROMPT, s_r.page + 2'h1, s_nxt.fld, 16'h0000};
                            end
                        end
                        CMD_DEF: begin
                            // wipes every field, so a programmed panel
                            // loses its settings; the code and keypad set
                            // return to their factory values
                            s_nxt.mem = '0;
                            s_nxt.mem[0][FLD_CODE] = CODE_DEF;
                            s_nxt.kp_en = KP_EN_DEF;
                            s_nxt.disp = '{DSP_PROMPT, s_r.page, s_r.fld, 16'h0000};
                        end
                        CMD_LOCK: begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.locked = 1'b1;
                            s_nxt.disp = '0;
                        end
                        CMD_BACK: begin
                            if (s_r.page != 2'h0) begin
                                s_nxt.page = s_r.page - 2'h1;
                                s_nxt.fld = (s_r.page == 2'h2) ? P1_MIN : FLD_CODE;
                                s_nxt.disp = '{DSP_PROMPT, s_r.page - 2'h1, s_nxt.fld, 16'h0000};
                            end else begin
                                s_nxt.st = ST_IDLE;
                                s_nxt.disp = '0;
                            end
                        end
                        default: begin
                            s_nxt.st = ST_CMD;
                        end
                    endcase
                end else if (is_dig) begin
                    fld_ok = addr_ok(s_r.page, num);
                    if (!fld_ok) begin
                        s_nxt.st = ST_CMD;
                        s_nxt.disp.mode = DSP_FC;
                    end else begin
                        s_nxt.fld = num;
                        if (!is_part(s_r.page, num)) begin
                            s_nxt.part_mode = 1'b0;
                        end
                        s_nxt.acc = '0;
                        s_nxt.cnt = '0;
                        if (s_r.rd) begin
                            s_nxt.st = ST_CMD;
                            s_nxt.disp = '{DSP_READ, s_r.page, num, s_r.mem[s_r.page][num]};
                        end else begin
                            s_nxt.st = ST_DATA;
                            s_nxt.disp = '{DSP_ENTRY, s_r.page, num, s_r.mem[s_r.page][num]};
                        end
                    end
                end
            end
            ST_PART: begin
                // one digit selects the partition; any other key is an
                // address error and leaves partition editing as it was
                if (is_dig) begin
                    s_nxt.part = key.code;
                    s_nxt.part_mode = 1'b1;
                    s_nxt.st = ST_CMD;
                    s_nxt.disp = '{DSP_PROMPT, 2'h0, PART_LO, {12'h000, key.code}};
                end else if (key.valid) begin
                    s_nxt.st = ST_CMD;
                    s_nxt.disp.mode = DSP_FC;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    // state register, synchronous reset loads factory values
    // reset clears lockout as well, which is the only way out of it;
    // the field store keeps only the installer code after reset, the
    // other fields read as zero until written
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.mem[0][FLD_CODE] <= CODE_DEF;
            s_r.kp_en <= KP_EN_DEF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    // every output is a register or a decode of the state register, so
    // the keypad side sees no glitches from the key path
    assign disp_out      = s_r.disp;
    assign prog_mode_out = (s_r.st != ST_IDLE);
    assign menu_mode_out = (s_r.st == ST_MENU);
    assign locked_out    = s_r.locked;
    assign part_mode_out = s_r.part_mode;
    assign part_sel_out  = s_r.part;
    assign beep3_out     = s_r.beep;
endmodule : kpi_interp

// File: design/kpi_pkg.sv
// shared constants and types for the keypad programming-mode interpreter
package kpi_pkg;
    // clock and power-up chord window
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned POWERUP_S      = 30;
    localparam logic [31:0] POWERUP_CYCLES = 32'(64'(POWERUP_S) * 64'(CLK_HZ));

    // key codes
    localparam logic [3:0] KEY_STAR  = 4'h A;
    localparam logic [3:0] KEY_POUND = 4'h B;
    localparam logic [3:0] KEY_DIG_MAX = 4'h 9;

    // field store geometry
    localparam int unsigned NPAGES  = 3;
    localparam int unsigned NFIELDS = 100;
    localparam int unsigned KP_N    = 32;
    localparam logic [1:0]  PAGE_LAST = 2'h 2;
    localparam logic [6:0]  P0_MAX  = 7'h 5A;   // field 90
    localparam logic [6:0]  P1_MIN  = 7'h 01;
    localparam logic [6:0]  P1_MAX  = 7'h 4C;   // field 76
    localparam logic [6:0]  P2_MAX  = 7'h 58;   // field 88
    localparam logic [6:0]  FLD_CODE = 7'h 00;  // installer code field

    // partition-specific range on the first page
    localparam logic [6:0]  PART_LO = 7'h 09;
    localparam logic [6:0]  PART_HI = 7'h 0E;

    // entry lengths and limits
    localparam logic [2:0]  LEN_CODE  = 3'h 4;
    localparam logic [2:0]  LEN_FIELD = 3'h 2;
    localparam logic [15:0] FIELD_MAX = 16'h 0015;
    localparam logic [15:0] CODE_DEF  = 16'h 4140;
    localparam logic [15:0] ENTER_TAIL = 16'h 8000;
    localparam logic [KP_N-1:0] KP_EN_DEF = 32'h 0000_0003;  // addresses 00-01
    localparam logic [15:0] SW_REV = 16'h 0001;  // arbitrary revision value

    // command codes
    localparam logic [6:0] CMD_PART = 7'd91;
    localparam logic [6:0] CMD_REV  = 7'd92;
    localparam logic [6:0] CMD_MENU = 7'd93;
    localparam logic [6:0] CMD_NEXT = 7'd94;
    localparam logic [6:0] CMD_DEF  = 7'd97;
    localparam logic [6:0] CMD_LOCK = 7'd98;
    localparam logic [6:0] CMD_BACK = 7'd99;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_CMD  = 7'b000_0010,
        ST_FLD1 = 7'b000_0100,
        ST_FLD2 = 7'b000_1000,
        ST_DATA = 7'b001_0000,
        ST_PART = 7'b010_0000,
        ST_MENU = 7'b100_0000
    } kpi_state_type;

    typedef enum logic [3:0] {
        DSP_OFF    = 4'h 0,
        DSP_PROMPT = 4'h 1,
        DSP_ENTRY  = 4'h 2,
        DSP_READ   = 4'h 3,
        DSP_FC     = 4'h 4,
        DSP_BLANK  = 4'h 5,
        DSP_REV    = 4'h 6,
        DSP_PARTQ  = 4'h 7,
        DSP_MENU   = 4'h 8
    } kpi_dmode_type;

    // keypad display image
    typedef struct packed {
        kpi_dmode_type mode;
        logic [1:0]    page;     // 0 none, 1 shows 100 banner, 2 shows 200 banner
        logic [6:0]    field;
        logic [15:0]   data;
    } kpi_disp_type;

    // one key event
    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } kpi_key_type;
endpackage : kpi_pkg

// File: test/kpi_interp_chk.sv
// concurrent checks on the interpreter's ports
`timescale 1ns/1ps
module kpi_interp_chk
    import kpi_pkg::*;
#(
    parameter logic [31:0] POWERUP_CYC = kpi_pkg::POWERUP_CYCLES
) (
    // clock and reset
    input wire logic         clk_in,
    input wire logic         rst_n_in,
    // inputs
    input wire kpi_key_type  kp_key_in,
    input wire logic         kp_chord_in,
    input wire logic [4:0]   kp_addr_in,
    input wire logic         kp_two_line_in,
    input wire kpi_key_type  dl_key_in,
    input wire logic         dl_enter_in,
    input wire logic         dl_local_dis_in,
    input wire logic [3:0]   part_count_in,
    // outputs
    input wire kpi_disp_type disp_out,
    input wire logic         prog_mode_out,
    input wire logic         menu_mode_out,
    input wire logic         locked_out,
    input wire logic         part_mode_out,
    input wire logic [3:0]   part_sel_out,
    input wire logic         beep3_out
);
    logic [31:0] cyc_r;
    // cycles since reset release, saturating, to judge the chord window
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) cyc_r <= 32'h0000_0000;
        else if (cyc_r != 32'hFFFF_FFFF) cyc_r <= cyc_r + 32'h0000_0001;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_beep_one_cycle: assert property (beep3_out |=> !beep3_out)
        else $error("beep pulse longer than one cycle");
    chk_beep_advance: assert property (beep3_out |-> prog_mode_out && disp_out.mode == DSP_ENTRY)
        else $error("beep without field advance");
    chk_chord_enters: assert property (!prog_mode_out && kp_chord_in && !dl_local_dis_in
        && cyc_r + 32'h0000_0004 < POWERUP_CYC |=> prog_mode_out)
        else $error("chord in window did not enter");
    chk_chord_late: assert property (!prog_mode_out && cyc_r > POWERUP_CYC + 32'h0000_0004
        && !kp_key_in.valid && !dl_key_in.valid && !dl_enter_in |=> !prog_mode_out)
        else $error("late chord entered");
    chk_local_dis: assert property (!prog_mode_out && dl_local_dis_in && !dl_enter_in
        && !dl_key_in.valid |=> !prog_mode_out)
        else $error("keypad entry while locally disabled");
    chk_lock_holds: assert property (locked_out |=> locked_out)
        else $error("lockout cleared without reset");
    chk_entry_prompt: assert property ($rose(prog_mode_out) |-> disp_out.mode == DSP_PROMPT
        && disp_out.page == 2'h0 && disp_out.field == 7'h00)
        else $error("entry prompt not at first page field 00");
    chk_menu_two_line: assert property ($rose(menu_mode_out) |-> $past(kp_two_line_in)
        || $past(dl_key_in.valid))
        else $error("menu entered from one-line keypad");
    chk_page_range: assert property (prog_mode_out |-> disp_out.page <= PAGE_LAST)
        else $error("page beyond the third");
    // main scenarios reached
    cover property ($rose(prog_mode_out));
    cover property ($rose(locked_out));
    cover property (beep3_out);
    cover property ($rose(menu_mode_out));
endmodule : kpi_interp_chk

// File: test/kpi_keypad.sv
// installer keypad model: key strings as one-cycle key pulses
`timescale 1ns/1ps
module kpi_keypad
    import kpi_pkg::*;
(
    input  wire logic  clk_in,
    output kpi_key_type key_out,
    output logic        chord_out
);
    initial key_out = '0;
    initial chord_out = 1'b0;
    // one key per pulse, code inverted once released
    task automatic send(input string s);
        logic [3:0] c;
        for (int i = 0; i < s.len(); i++) begin
            c = (s[i] == "*") ? KEY_STAR : (s[i] == "#") ? KEY_POUND : 4'(s[i] - "0");
            @(negedge clk_in);
            key_out <= {1'b1, c};
            @(negedge clk_in);
            key_out <= {1'b0, ~c};
        end
    endtask : send
    // star and pound held together for one cycle
    task automatic chord();
        @(negedge clk_in);
        chord_out <= 1'b1;
        @(negedge clk_in);
        chord_out <= 1'b0;
    endtask : chord
endmodule : kpi_keypad

// File: test/tb_keypad_program_mode_interpreter.sv
// self-checking bench for the keypad programming-mode interpreter
`timescale 1ns/1ps
module tb_keypad_program_mode_interpreter;
    import kpi_pkg::*;
    localparam logic [31:0] PU = 32'h0000_00C8;
    logic         clk_in = 1'b0, rst_n_in = 1'b0, dl_enter = 1'b0, dl_dis = 1'b0;
    logic         two_line = 1'b0, chord, prog, menu, locked, pmode, beep;
    logic [3:0]   part_count = 4'h2, psel;
    logic [4:0]   kp_addr = 5'h00;
    logic [15:0]  code = CODE_DEF;
    kpi_key_type  kp_key, dl_key = '0;
    kpi_disp_type disp;
    int           miscompares = 0, checked = 0, cyc = 0, mem[int];
    kpi_interp #(.POWERUP_CYC(PU)) kpi_interp_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .kp_key_in(kp_key), .kp_chord_in(chord), .kp_addr_in(kp_addr),
        .kp_two_line_in(two_line), .dl_key_in(dl_key), .dl_enter_in(dl_enter),
        .dl_local_dis_in(dl_dis), .part_count_in(part_count), .disp_out(disp),
        .prog_mode_out(prog), .menu_mode_out(menu), .locked_out(locked),
        .part_mode_out(pmode), .part_sel_out(psel), .beep3_out(beep));
    kpi_keypad kpi_keypad_i (.clk_in(clk_in), .key_out(kp_key), .chord_out(chord));
    initial forever #5 clk_in = ~clk_in;
    // hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    function automatic logic [31:0] dd(kpi_dmode_type m, logic [1:0] p, int f, int d);
        return 32'({m, p, 7'(f), 16'(d)});
    endfunction : dd
    // write a two-digit field and update the model
    task automatic wr(input int f, input logic [7:0] v);
        kpi_keypad_i.send($sformatf("*%02d%02h", f, v));
        check("beep", beep, v <= FIELD_MAX);
        if (v <= FIELD_MAX) mem[f] = v;
    endtask : wr
    task automatic rd(input int f);
        kpi_keypad_i.send($sformatf("#%02d", f));
        check("read", disp, dd(DSP_READ, 0, f, mem.exists(f) ? mem[f] : 0));
    endtask : rd
    // link keys, one per pulse, as the downloading side would send them
    task automatic dl_send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clk_in);
            dl_key = {1'b1, (s[i] == "*") ? KEY_STAR : 4'(s[i] - "0")};
            @(negedge clk_in);
            dl_key = '0;
        end
    endtask : dl_send
    task automatic enter_code();
        kpi_keypad_i.send($sformatf("%04h8000", code));
    endtask : enter_code
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(32'h38b9acf1));
        repeat (5) @(negedge clk_in);
        rst_n_in = 1'b1;
        check("reset", {prog, locked, disp.mode}, 0);
        kpi_keypad_i.chord();
        check("chord", prog, 1);
        check("prompt", disp, dd(DSP_PROMPT, 0, 0, 0));
        kpi_keypad_i.send("*99");
        check("exit", prog, 0);
        $display("test 1 done");
        enter_code();
        check("code", prog, 1);
        kpi_keypad_i.send("*97");
        mem.delete();
        mem[0] = CODE_DEF;
        rd(0);
        for (int f = 2; f < 6; f++) begin
            wr(f, 8'(($urandom % 2) * 16 + $urandom % 6));
            check("next", disp, dd(DSP_ENTRY, 0, f + 1, 0));
        end
        for (int f = 2; f < 6; f++) rd(f);
        wr(2, 8'h99);
        check("blank", disp.mode, DSP_BLANK);
        rd(2);
        kpi_keypad_i.send("*051");
        check("short", {disp.mode, disp.field}, {DSP_ENTRY, 7'd5});
        rd(5);
        kpi_keypad_i.send("#95");
        check("fc", disp.mode, DSP_FC);
        wr(8, 8'h01);
        check("skip", disp.field, 15);
        part_count = 4'h1;
        wr(8, 8'h01);
        check("noskip", disp.field, 9);
        kpi_keypad_i.send("*912");
        check("part", {pmode, psel}, 5'h12);
        wr(14, 8'h01);
        check("back", {pmode, disp.field}, 0);
        code = 16'(($urandom % 10) << 12 | ($urandom % 10) << 8 | 16'h0012);
        kpi_keypad_i.send($sformatf("*00%04h", code));
        check("beep", beep, 1);
        kpi_keypad_i.send("*92");
        check("rev", disp.data, SW_REV);
        $display("test 2 done");
        kpi_keypad_i.send("*94");
        check("p1", {disp.page, disp.field}, {2'h1, P1_MIN});
        kpi_keypad_i.send("*94");
        check("p2", {disp.page, disp.field}, 9'h100);
        kpi_keypad_i.send("*94");
        check("p2max", disp.page, 2);
        kpi_keypad_i.send("*99*99*99");
        check("exit99", prog, 0);
        enter_code();
        check("again", prog, 1);
        kpi_keypad_i.send("*98");
        check("lock", {prog, locked}, 2'b01);
        enter_code();
        kpi_keypad_i.chord();
        check("locked", prog, 0);
        $display("test 3 done");
        rst_n_in = 1'b0;
        @(negedge clk_in);
        rst_n_in = 1'b1;
        code = CODE_DEF;
        kp_addr = 5'h05;
        enter_code();
        check("addr5", prog, 0);
        dl_dis = 1'b1;
        kp_addr = 5'h01;
        enter_code();
        kpi_keypad_i.chord();
        check("dis", prog, 0);
        dl_dis = 1'b0;
        enter_code();
        check("addr1", prog, 1);
        kpi_keypad_i.send("*93");
        check("menu1", {menu, disp.mode}, {1'b0, DSP_FC});
        two_line = 1'b1;
        kpi_keypad_i.send("*93");
        check("menu2", menu, 1);
        kpi_keypad_i.send("*");
        check("menuq", menu, 0);
        kpi_keypad_i.send("99");
        check("out", prog, 0);
        dl_dis = 1'b1;
        two_line = 1'b0;
        kp_addr = 5'h05;
        @(negedge clk_in);
        dl_enter = 1'b1;
        @(negedge clk_in);
        dl_enter = 1'b0;
        check("dlenter", prog, 1);
        dl_send("*93");
        check("dlmenu", menu, 1);
        dl_send("*98");
        check("dllock", {prog, locked}, 2'b01);
        $display("test 4 done");
        finish_test();
    end
endmodule : tb_keypad_program_mode_interpreter
bind kpi_interp kpi_interp_chk #(.POWERUP_CYC(POWERUP_CYC)) kpi_interp_chk_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .kp_key_in(kp_key_in), .kp_chord_in(kp_chord_in),
    .kp_addr_in(kp_addr_in), .kp_two_line_in(kp_two_line_in), .dl_key_in(dl_key_in),
    .dl_enter_in(dl_enter_in), .dl_local_dis_in(dl_local_dis_in),
    .part_count_in(part_count_in), .disp_out(disp_out), .prog_mode_out(prog_mode_out),
    .menu_mode_out(menu_mode_out), .locked_out(locked_out), .part_mode_out(part_mode_out),
    .part_sel_out(part_sel_out), .beep3_out(beep3_out));
